//--- bench/ext_regulator_config_ctrl_test.sv
`timescale 1ns/1ps
module ext_regulator_config_ctrl_test;
	import ext_reg_pkg::*;
	// ----------------------------------------
	// stimulus and observation
	// ----------------------------------------
	logic clk_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic soft_reset_i = 1'b0;
	dev_mode_t mode_i = MODE_INIT;
	sw_ctrl_t sw_i = '0;
	logic main_supply_on_i = 1'b0;
	logic battery_undervoltage_i = 1'b0;
	logic heavy_load = 1'b0;      // load step request to the partner
	logic peak_rise;
	logic peak_fall;
	logic third_supply_on_o;
	logic output_level_select_o;
	logic hp_reg_en_o;
	logic lp_reg_en_o;
	logic prot_en_o;
	logic spi_fail_o;
	supply_status_t status_o;
	int n_fail = 0;
	int num_checks = 0;
	int n_pulse = 0;              // failure pulses seen so far
	wire [4:0] outs = {third_supply_on_o, output_level_select_o, hp_reg_en_o, lp_reg_en_o,
		prot_en_o};
	initial forever #10 clk_i = ~clk_i;
	// one-cycle pulse, so count it at every edge rather than poll it
	always @(posedge clk_i) if (spi_fail_o === 1'b1) n_pulse <= n_pulse + 1;
	ext_regulator_config_ctrl ext_regulator_config_ctrl_inst (.clk_i(clk_i),
		.arst_n_i(arst_n_i), .soft_reset_i(soft_reset_i), .mode_i(mode_i), .sw_i(sw_i),
		.main_supply_on_i(main_supply_on_i), .battery_undervoltage_i(battery_undervoltage_i),
		.base_peak_rise_i(peak_rise), .base_peak_fall_i(peak_fall),
		.third_supply_on_o(third_supply_on_o), .output_level_select_o(output_level_select_o),
		.hp_reg_en_o(hp_reg_en_o), .lp_reg_en_o(lp_reg_en_o), .prot_en_o(prot_en_o),
		.spi_fail_o(spi_fail_o), .status_o(status_o));
	pnp_shunt_model pnp_shunt_model_inst (.clk_i(clk_i), .drive_on_i(third_supply_on_o),
		.heavy_load_i(heavy_load), .base_peak_rise_o(peak_rise), .base_peak_fall_o(peak_fall));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic chk(string what, logic [7:0] e, logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", what, e, g);
		end
	endtask : chk
	task automatic on_is(logic e);
		chk("supply on", {7'h0, e}, {7'h0, third_supply_on_o});
	endtask : on_is
	// order: on, level, high power, low power, protection
	task automatic outs_are(logic [4:0] e);
		chk("outputs", {3'h0, e}, {3'h0, outs});
	endtask : outs_are
	// one write strobe, bits = standalone, share, level, keep, latch
	task automatic wr(logic m, logic h, logic [4:0] b);
		sw_i <= {m, h, b};
		@(posedge clk_i);
		sw_i <= '0;
		repeat (4) @(posedge clk_i);
	endtask : wr
	task automatic go(dev_mode_t m);
		mode_i <= m;
		repeat (5) @(posedge clk_i);
	endtask : go
	task automatic uv(logic v);
		battery_undervoltage_i <= v;
		repeat (6) @(posedge clk_i);  // pins need the synchroniser first
	endtask : uv
	// soft reset pulse; the lock must outlive it
	task automatic soft_rst();
		soft_reset_i <= 1'b1;
		@(posedge clk_i);
		soft_reset_i <= 1'b0;
		repeat (5) @(posedge clk_i);
	endtask : soft_rst
	// power loss: the only thing that may clear the lock
	task automatic power_up();
		arst_n_i <= 1'b0;
		mode_i <= MODE_NORMAL;
		repeat (12) @(posedge clk_i);
		arst_n_i <= 1'b1;
		repeat (4) @(posedge clk_i);
	endtask : power_up
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic sa_lock();
		int p;
		power_up();
		on_is(1'b0);
		wr(1'b1, 1'b0, 5'b10100);
		outs_are(5'b11101);
		chk("status", 8'he5, status_o);
		p = n_pulse;
		wr(1'b0, 1'b1, 5'b01000);
		wr(1'b1, 1'b0, 5'b10000);
		outs_are(5'b11101);
		chk("pulses", 8'h00, 8'(n_pulse - p));
		wr(1'b1, 1'b0, 5'b00100);
		on_is(1'b0);
		wr(1'b1, 1'b0, 5'b10100);
		on_is(1'b1);
	endtask : sa_lock
	task automatic sa_modes();
		go(MODE_STOP);
		outs_are(5'b11011);
		heavy_load <= 1'b1;
		repeat (6) @(posedge clk_i);
		outs_are(5'b11111);
		heavy_load <= 1'b0;
		repeat (6) @(posedge clk_i);
		outs_are(5'b11011);
		go(MODE_SLEEP);
		on_is(1'b1);
		go(MODE_RESTART);
		on_is(1'b1);
		go(MODE_FAILSAFE);
		on_is(1'b0);
		go(MODE_NORMAL);
		on_is(1'b1);
		uv(1'b1);
		on_is(1'b0);
		chk("uv flag", 8'h01, {7'h0, status_o.uv_shutdown});
		uv(1'b0);
		on_is(1'b1);
		soft_rst();
		chk("status", 8'he5, status_o);
	endtask : sa_modes
	task automatic ls_lock();
		int p;
		power_up();
		go(MODE_INIT);
		on_is(1'b0);
		go(MODE_NORMAL);
		wr(1'b1, 1'b0, 5'b00100);
		wr(1'b0, 1'b1, 5'b01000);
		outs_are(5'b10100);
		chk("status", 8'h94, status_o);
		p = n_pulse;
		wr(1'b1, 1'b0, 5'b10000);
		wr(1'b0, 1'b1, 5'b00000);
		chk("pulses", 8'h02, 8'(n_pulse - p));
		outs_are(5'b10100);
	endtask : ls_lock
	task automatic ls_modes();
		go(MODE_STOP);
		on_is(1'b0);
		go(MODE_NORMAL);
		on_is(1'b1);
		wr(1'b0, 1'b1, 5'b01010);
		go(MODE_STOP);
		on_is(1'b1);
		outs_are(5'b10010);
		go(MODE_SLEEP);
		on_is(1'b0);
		main_supply_on_i <= 1'b1;
		go(MODE_RESTART);
		on_is(1'b1);
		main_supply_on_i <= 1'b0;
		go(MODE_NORMAL);
		wr(1'b0, 1'b1, 5'b01001);
		uv(1'b1);
		on_is(1'b0);
		uv(1'b0);
		on_is(1'b0);
		soft_rst();
		on_is(1'b1);
		chk("status", 8'h94, status_o);
	endtask : ls_modes
	// ----------------------------------------
	// verdict, watchdog and main sequence
	// ----------------------------------------
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : tally_and_finish
	// whole run is a few hundred cycles; this only cuts a hang
	initial begin
		repeat (5000) @(posedge clk_i);
		n_fail++;
		tally_and_finish();
	end
	initial begin
		sa_lock();
		sa_modes();
		ls_lock();
		ls_modes();
		tally_and_finish();
	end
endmodule : ext_regulator_config_ctrl_test

//--- bench/pnp_shunt_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// pass transistor and shunt, as seen by the base current comparators
// ----------------------------------------
module pnp_shunt_model (
	input wire logic clk_i,
	input wire logic drive_on_i,    // regulator driving the base
	input wire logic heavy_load_i,  // bench asks for a load step
	output logic base_peak_rise_o,
	output logic base_peak_fall_o
);
	// no base current at all while the regulator is off, so both comparators rest low
	always_ff @(posedge clk_i) begin
		base_peak_rise_o <= drive_on_i & heavy_load_i;
		base_peak_fall_o <= drive_on_i & ~heavy_load_i;
	end
endmodule : pnp_shunt_model

//--- logic/ext_reg_pkg.sv
package ext_reg_pkg;
	// ----------------------------------------
	// operating modes of the device
	// ----------------------------------------
	typedef enum logic [2:0] {
		MODE_INIT = 3'h0,
		MODE_NORMAL = 3'h1,
		MODE_STOP = 3'h2,
		MODE_SLEEP = 3'h3,
		MODE_RESTART = 3'h4,
		MODE_FAILSAFE = 3'h5
	} dev_mode_t;

	// ----------------------------------------
	// configuration lock states
	// ----------------------------------------
	typedef enum logic [1:0] {
		CFG_NONE = 2'h0,
		CFG_STANDALONE = 2'h1,
		CFG_LOADSHARE = 2'h2
	} cfg_state_t;

	// software write strobe with its control bits
	typedef struct packed {
		logic wr_mode_ctrl;              // write to mode/supply control register
		logic wr_hardware_control;                // write to hardware control register
		logic standalone_enable;
		logic load_share_select;
		logic output_level_select;
		logic load_share_keep_in_stop;
		logic undervoltage_latch_off;
	} sw_ctrl_t;

	// status word reported in the second supply status register
	typedef struct packed {
		logic supply_on;
		logic level_1v8;
		logic cfg_standalone;
		logic cfg_loadshare;
		logic uv_shutdown;
		logic hp_active;
		logic lp_active;
		logic prot_active;
	} supply_status_t;

	localparam logic [1:0] SYNC_STAGES = 2'h2;
	localparam logic OUT_LEVEL_3V3 = 1'b0;
	localparam logic OUT_LEVEL_1V8 = 1'b1;
	localparam logic RST_ON = 1'b0;
endpackage : ext_reg_pkg

//--- logic/ext_regulator_config_ctrl.sv
`timescale 1ns/1ps
module ext_regulator_config_ctrl
	import ext_reg_pkg::*;
(
	input wire logic clk_i,
	input wire logic arst_n_i,              // power-on reset only
	input wire logic soft_reset_i,          // device soft reset, same clock
	input wire dev_mode_t mode_i,           // current device mode
	input wire sw_ctrl_t sw_i,              // software write, same clock
	input wire logic main_supply_on_i,      // main supply on or ramping
	input wire logic battery_undervoltage_i, // comparator pin
	input wire logic base_peak_rise_i,      // base current above rising threshold
	input wire logic base_peak_fall_i,      // base current below falling threshold
	output logic third_supply_on_o,
	output logic output_level_select_o,     // 1 = 1.8V target
	output logic hp_reg_en_o,
	output logic lp_reg_en_o,
	output logic prot_en_o,                 // undervoltage and shunt limit
	output logic spi_fail_o,                // one-cycle pulse
	output supply_status_t status_o
);
	// ----------------------------------------
	// reset release and pin sync
	// ----------------------------------------
	logic [1:0] rst_pipe; // reset release stages
	logic rst_n;
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rst_pipe <= 2'h0;
		end else begin
			rst_pipe <= {rst_pipe[0], 1'b1};
		end
	end
	assign rst_n = rst_pipe[1];

	logic [2:0] pins_s; // synced uv, rise, fall
	pin_sync #(.WIDTH(3)) pin_sync_inst (
		.clk_i(clk_i),
		.rst_n_i(rst_n),
		.async_i({battery_undervoltage_i, base_peak_rise_i, base_peak_fall_i}),
		.sync_o(pins_s)
	);
	logic uv_s;
	logic rise_s;
	logic fall_s;
	assign uv_s = pins_s[2];
	assign rise_s = pins_s[1];
	assign fall_s = pins_s[0];

	// ----------------------------------------
	// configuration state
	// ----------------------------------------
	cfg_state_t cfg, next_cfg;        // only power-on reset clears it
	logic level, next_level;          // output level select
	logic sa_on, next_sa_on;          // stand-alone on/off request
	logic keep_stop, next_keep_stop;
	logic latch_off, next_latch_off;
	logic uv_latched, next_uv_latched; // latched undervoltage shutdown
	logic hp_stop, next_hp_stop;      // high-power added in stop
	logic fail, next_fail;

	// next-state of configuration and controls
	always_comb begin
		next_cfg = cfg;
		next_level = level;
		next_sa_on = sa_on;
		next_keep_stop = keep_stop;
		next_latch_off = latch_off;
		next_fail = 1'b0;
		if (sw_i.wr_hardware_control) begin
			next_keep_stop = sw_i.load_share_keep_in_stop;
			next_latch_off = sw_i.undervoltage_latch_off;
		end
		// soft reset clears the stop and latch-off controls, never the lock
		if (soft_reset_i) begin
			next_keep_stop = 1'b0;
			next_latch_off = 1'b0;
		end
		// lock states: only the first configuration write counts
		unique case (cfg)
			CFG_NONE: begin
				// load share wins if both requested at once
				if (sw_i.wr_hardware_control && sw_i.load_share_select) begin
					next_cfg = CFG_LOADSHARE;
				end else if (sw_i.wr_mode_ctrl && sw_i.standalone_enable
						&& mode_i == MODE_NORMAL) begin
					next_cfg = CFG_STANDALONE;
					next_sa_on = 1'b1;
					next_level = sw_i.output_level_select;
				end else if (sw_i.wr_mode_ctrl) begin
					next_level = sw_i.output_level_select;
				end
			end
			CFG_STANDALONE: begin
				// on/off still writable in normal, config fixed silently
				if (sw_i.wr_mode_ctrl && mode_i == MODE_NORMAL) begin
					next_sa_on = sw_i.standalone_enable;
				end
				// change attempts ignored without flag
			end
			CFG_LOADSHARE: begin
				if ((sw_i.wr_hardware_control && !sw_i.load_share_select)
						|| (sw_i.wr_mode_ctrl && sw_i.standalone_enable)) begin
					next_fail = 1'b1;
				end
			end
			default: begin
				next_cfg = CFG_NONE;
			end
		endcase
	end

	// config registers: soft reset reaches only keep_stop and latch_off, through the next-state logic
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			cfg <= CFG_NONE;
			level <= OUT_LEVEL_3V3;
			sa_on <= RST_ON;
			keep_stop <= 1'b0;
			latch_off <= 1'b0;
			fail <= 1'b0;
		end else begin
			cfg <= next_cfg;
			level <= next_level;
			sa_on <= next_sa_on;
			keep_stop <= next_keep_stop;
			latch_off <= next_latch_off;
			fail <= next_fail;
		end
	end

	// ----------------------------------------
	// supply on/off decision
	// ----------------------------------------
	// ----------------------------------------
	// decode helpers
	// ----------------------------------------
	// stand-alone demand, decoded in several modes
	function automatic logic sa_demand(cfg_state_t c, logic on);
		return (c == CFG_STANDALONE) && on;
	endfunction : sa_demand

	logic want_on; // mode-based demand before undervoltage
	logic next_on; // supply on after undervoltage
	logic next_hp; // high-power stage enable
	logic next_lp; // low-power stage enable
	logic next_level_o; // level pin, held at main level in load share
	logic next_prot; // protections armed
	supply_status_t next_status; // word for software readback
	// mode_i is on this clock already, so it is read without a synchroniser
	always_comb begin
		want_on = 1'b0;
		unique case (mode_i)
			MODE_INIT, MODE_FAILSAFE: want_on = 1'b0;
			MODE_NORMAL: want_on = (cfg == CFG_LOADSHARE) || sa_demand(cfg, sa_on);
			MODE_STOP: want_on = (cfg == CFG_LOADSHARE) ? keep_stop
				: sa_demand(cfg, sa_on);
			// sleep: load share follows the main supply, which is off
			MODE_SLEEP: want_on = sa_demand(cfg, sa_on);
			MODE_RESTART: want_on = (cfg == CFG_LOADSHARE) ? main_supply_on_i
				: sa_demand(cfg, sa_on);
			default: want_on = 1'b0;
		endcase
		// undervoltage latch: set wins, auto release unless latch-off
		next_uv_latched = uv_latched;
		if (uv_s) begin
			next_uv_latched = 1'b1;
		end else if (!latch_off) begin
			next_uv_latched = 1'b0;
		end else if (sw_i.wr_mode_ctrl && sw_i.standalone_enable && mode_i == MODE_NORMAL) begin
			next_uv_latched = 1'b0; // software re-enables after latch-off
		end
		next_on = want_on && !uv_s && !next_uv_latched;
		// stop hysteresis between low- and high-power stages
		next_hp_stop = hp_stop;
		if (mode_i != MODE_STOP) begin
			next_hp_stop = 1'b0;
		end else if (rise_s) begin
			next_hp_stop = 1'b1;
		end else if (fall_s) begin
			next_hp_stop = 1'b0;
		end
		next_hp = next_on && (mode_i != MODE_STOP || next_hp_stop);
		next_lp = next_on && (mode_i == MODE_STOP);
		// load sharing regulates at the main level, 3.3V, whatever the bit says
		next_level_o = (cfg == CFG_STANDALONE) ? level : OUT_LEVEL_3V3;
		// shunt limit and undervoltage shutdown only make sense stand-alone
		next_prot = next_on && (cfg == CFG_STANDALONE);
		// status mirrors what goes to the pins at this same edge
		next_status = '{supply_on: next_on,
			level_1v8: (cfg == CFG_STANDALONE) && level,
			cfg_standalone: cfg == CFG_STANDALONE,
			cfg_loadshare: cfg == CFG_LOADSHARE,
			uv_shutdown: next_uv_latched,
			hp_active: next_hp,
			lp_active: next_lp,
			prot_active: next_prot};
	end

	// output registers
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			uv_latched <= 1'b0;
			hp_stop <= 1'b0;
			third_supply_on_o <= 1'b0;
			hp_reg_en_o <= 1'b0;
			lp_reg_en_o <= 1'b0;
			output_level_select_o <= OUT_LEVEL_3V3;
			prot_en_o <= 1'b0;
			spi_fail_o <= 1'b0;
			status_o <= '0;
		end else begin
			uv_latched <= next_uv_latched;
			hp_stop <= next_hp_stop;
			third_supply_on_o <= next_on;
			hp_reg_en_o <= next_hp;
			lp_reg_en_o <= next_lp;
			// outputs only register what the decision logic worked out
			output_level_select_o <= next_level_o;
			prot_en_o <= next_prot;
			spi_fail_o <= fail;
			status_o <= next_status;
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	// configuration lock, failure flag, off modes, undervoltage, protection, stages in normal and load sharing in stop
	chk_lock_holds: assert property (@(posedge clk_i) disable iff (!rst_n)
		cfg != CFG_NONE |=> cfg == $past(cfg))
		else $error("locked configuration changed");
	chk_soft_keep: assert property (@(posedge clk_i) disable iff (!rst_n)
		soft_reset_i && cfg != CFG_NONE |=> cfg == $past(cfg))
		else $error("soft reset cleared configuration");
	chk_off_modes: assert property (@(posedge clk_i) disable iff (!rst_n)
		(mode_i == MODE_INIT || mode_i == MODE_FAILSAFE) |=> !third_supply_on_o)
		else $error("supply on in init or fail-safe");
	chk_uv_off: assert property (@(posedge clk_i) disable iff (!rst_n)
		uv_s |=> !third_supply_on_o)
		else $error("supply on during undervoltage");
	chk_ls_fail: assert property (@(posedge clk_i) disable iff (!rst_n)
		cfg == CFG_LOADSHARE && sw_i.wr_hardware_control && !sw_i.load_share_select |=> ##1 spi_fail_o)
		else $error("no failure flag after load-share change");
	chk_sa_nofail: assert property (@(posedge clk_i) disable iff (!rst_n)
		cfg == CFG_STANDALONE |=> ##1 !spi_fail_o)
		else $error("failure flag in stand-alone");
	chk_prot_sa: assert property (@(posedge clk_i) disable iff (!rst_n)
		prot_en_o |-> $past(cfg) == CFG_STANDALONE)
		else $error("protection active outside stand-alone");
	chk_normal_hp: assert property (@(posedge clk_i) disable iff (!rst_n)
		mode_i == MODE_NORMAL |=> !lp_reg_en_o)
		else $error("low-power stage used in normal mode");
	chk_ls_stop: assert property (@(posedge clk_i) disable iff (!rst_n)
		cfg == CFG_LOADSHARE && mode_i == MODE_STOP && !keep_stop |=> !third_supply_on_o)
		else $error("load sharing active in stop");
	// load-sharing level, mode behaviour and regulator stages; lock and recovery coverage
	chk_level_ls: assert property (@(posedge clk_i) disable iff (!rst_n)
		cfg == CFG_LOADSHARE |=> output_level_select_o == OUT_LEVEL_3V3)
		else $error("level bit applied in load sharing");
	chk_keep_stop: assert property (@(posedge clk_i) disable iff (!rst_n)
		cfg == CFG_LOADSHARE && mode_i == MODE_STOP && keep_stop && !uv_s && !uv_latched
		|=> third_supply_on_o)
		else $error("load sharing dropped in stop with keep bit");
	chk_ls_sleep: assert property (@(posedge clk_i) disable iff (!rst_n)
		cfg == CFG_LOADSHARE && mode_i == MODE_SLEEP |=> !third_supply_on_o)
		else $error("load sharing on in sleep");
	chk_lp_stop: assert property (@(posedge clk_i) disable iff (!rst_n)
		mode_i != MODE_STOP |=> !lp_reg_en_o)
		else $error("low-power stage outside stop");
	cov_sa_lock: cover property (@(posedge clk_i) disable iff (!rst_n)
		cfg == CFG_NONE ##1 cfg == CFG_STANDALONE);
	cov_ls_lock: cover property (@(posedge clk_i) disable iff (!rst_n)
		cfg == CFG_NONE ##1 cfg == CFG_LOADSHARE);
	cov_uv_recover: cover property (@(posedge clk_i) disable iff (!rst_n)
		third_supply_on_o ##1 !third_supply_on_o ##[1:20] third_supply_on_o);
	// coverage: stage mix in stop, refused change after load sharing
	cov_stop_hp: cover property (@(posedge clk_i) disable iff (!rst_n)
		lp_reg_en_o && hp_reg_en_o);
	cov_ls_fail: cover property (@(posedge clk_i) disable iff (!rst_n)
		cfg == CFG_LOADSHARE && spi_fail_o);
endmodule : ext_regulator_config_ctrl

//--- logic/pin_sync.sv
`timescale 1ns/1ps
// two-stage synchroniser for a bundle of pin levels
module pin_sync
	import ext_reg_pkg::*;
#(
	parameter int WIDTH = 3
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);
	// ----------------------------------------
	// stages
	// ----------------------------------------
	logic [WIDTH-1:0] meta; // read only by the second stage
	logic [WIDTH-1:0] next_meta;
	logic [WIDTH-1:0] next_sync;

	// next values: plain shift
	always_comb begin
		next_meta = async_i;
		next_sync = meta;
	end

	// registers
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta <= '0;
			sync_o <= '0;
		end else begin
			meta <= next_meta;
			sync_o <= next_sync;
		end
	end
endmodule : pin_sync
